// ---- ict_pkg.sv ----
// =====================================================================
// Shared types and constants of the instruction cycle timing core.
package ict_pkg;

  // =====================================================================
  // Clock and bus cycle figures.
  localparam int CLK_PERIOD_NS = 50;
  localparam logic [1:0] BUS_LAST_PHASE = 2'h3;
  localparam logic [7:0] PREDEC_EXTRA = 8'h02;
  localparam logic [7:0] LONG_DEST_EXTRA = 8'h04;
  localparam logic [7:0] PREDEC_DEST_PERIODS = 8'h04;
  localparam logic [3:0] BW_DEST_WRITES = 4'h1;
  localparam logic [3:0] LONG_DEST_WRITES = 4'h2;

  // =====================================================================
  // Operand modes and request kinds.
  typedef enum logic [3:0] {
    M_DREG = 4'h0, M_AREG = 4'h1, M_IND = 4'h2, M_POST = 4'h3,
    M_PRE = 4'h4, M_DISP = 4'h5, M_INDEX = 4'h6, M_ABSW = 4'h7,
    M_ABSL = 4'h8, M_PCDISP = 4'h9, M_PCINDEX = 4'ha, M_IMM = 4'hb
  } ict_mode_e;

  typedef enum logic {OP_EA = 1'b0, OP_MOVE = 1'b1} ict_op_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_READ = 4'b0010, ST_INTERN = 4'b0100, ST_WRITE = 4'b1000
  } ict_state_e;

  // =====================================================================
  // Carriers.
  typedef struct packed {
    ict_op_e op;
    logic size_long;
    logic fetch;
    ict_mode_e src;
    ict_mode_e dst;
    logic loop_candidate;
    logic branch_to_self;
    logic loop_condition;
    logic count_expired;
  } ict_req_s;

  typedef struct packed {
    logic [7:0] periods;
    logic [3:0] reads;
    logic [3:0] writes;
  } ict_cost_s;

  typedef struct packed {
    logic [15:0] periods;
    logic [3:0] reads;
    logic [3:0] writes;
    logic [15:0] waits;
  } ict_result_s;

  typedef struct packed {
    ict_state_e state;
    logic [1:0] phase;
    logic [3:0] rd_left;
    logic [3:0] wr_left;
    logic [7:0] idle_left;
    logic [15:0] periods;
    logic [15:0] waits;
    logic [3:0] rd_done;
    logic [3:0] wr_done;
    ict_cost_s plan;
    logic is_ea;
    logic loop_active;
    logic done;
    ict_result_s result;
    logic [2:0] wait_sync;
    logic wait_q;
  } ict_st_s;

  // =====================================================================
  // Fixed costs of the move and loop forms.
  localparam ict_cost_s OPCODE_COST = '{8'h04, 4'h1, 4'h0};
  localparam ict_cost_s LOOP_CONT_REG = '{8'h0a, 4'h0, 4'h1};
  localparam ict_cost_s LOOP_CONT_MEM = '{8'h0e, 4'h1, 4'h1};
  localparam ict_cost_s LOOP_TRUE_REG = '{8'h12, 4'h2, 4'h1};
  localparam ict_cost_s LOOP_TRUE_MEM = '{8'h14, 4'h3, 4'h1};
  localparam ict_cost_s LOOP_EXP_REG = '{8'h10, 4'h2, 4'h1};
  localparam ict_cost_s LOOP_EXP_MEM = '{8'h12, 4'h3, 4'h1};

endpackage

// ---- ict_core.sv ----
`timescale 1ns/1ps

// How it works
// R1 - Unstretched read or write cycle lasts four periods.
// R2 - Each memory wait period adds to total.
// R3 - Totals include opcode fetch, operand reads and writes.
// R4 - Non-bus periods leave the bus idle.
// R5 - Address computation never writes; includes extension reads except for byte/word displacement without fetch.
// R6 - Register direct operands cost nothing.
// R7 - Indirect and postincrement address costs.
// R8 - Predecrement and displacement address costs.
// R9 - Indexed and absolute short address costs.
// R10 - Absolute long and counter displacement costs.
// R11 - Counter indexed and immediate costs, fetch only.
// R12 - Index register size never changes timing.
// R13 - Byte/word moves from a register source.
// R14 - Byte/word moves from memory sources.
// R15 - Loop continuing: no opcode fetch, loop table.
// R16 - Loop ending on true condition costs more.
// R17 - Loop ending on expired count costs.
// R18 - Loop entered only for looping single-word instruction.
// R19 - Long moves use two writes per operand.
module ict_core #(
  parameter int COUNT_W = 16
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire ict_pkg::ict_req_s req_in,
  output logic req_ready_out,
  input wire logic mem_wait_in,
  output logic bus_start_out,
  output logic bus_read_out,
  output logic bus_write_out,
  output logic done_out,
  output ict_pkg::ict_result_s result_out,
  output logic loop_active_out,
  output logic opcode_fetch_skip_out
);
  import ict_pkg::*;

  if (COUNT_W != 16) begin : g_chk
    $error("COUNT_W must match the 16-bit result carrier");
  end

  // =====================================================================
  // Cost lookup.
  function automatic ict_cost_s ea_cost(ict_mode_e m, logic lng, logic fetch);
    ict_cost_s c;
    c = '0;
    case (m)
      M_DREG, M_AREG: c = '0; // R6
      M_IND: c = fetch ? (lng ? '{8'h08, 4'h2, 4'h0} : '{8'h04, 4'h1, 4'h0}) : '{8'h02, 4'h0, 4'h0}; // R7
      M_POST: c = fetch ? (lng ? '{8'h08, 4'h2, 4'h0} : '{8'h04, 4'h1, 4'h0}) : '{8'h04, 4'h0, 4'h0}; // R7
      M_PRE: c = fetch ? (lng ? '{8'h0a, 4'h2, 4'h0} : '{8'h06, 4'h1, 4'h0}) : '{8'h04, 4'h0, 4'h0}; // R8
      M_DISP: begin
        if (fetch) begin
          c = lng ? '{8'h0c, 4'h3, 4'h0} : '{8'h08, 4'h2, 4'h0}; // R8
        end else begin
          c = lng ? '{8'h04, 4'h1, 4'h0} : '{8'h04, 4'h0, 4'h0}; // R8
        end
      end
      // The index register size is not an input: both sizes share one cost.
      M_INDEX: c = fetch ? (lng ? '{8'h0e, 4'h3, 4'h0} : '{8'h0a, 4'h2, 4'h0}) : '{8'h08, 4'h1, 4'h0}; // R9 R12
      M_ABSW: c = fetch ? (lng ? '{8'h0c, 4'h3, 4'h0} : '{8'h08, 4'h2, 4'h0}) : '{8'h04, 4'h1, 4'h0}; // R9
      M_ABSL: c = fetch ? (lng ? '{8'h10, 4'h4, 4'h0} : '{8'h0c, 4'h3, 4'h0}) : '{8'h08, 4'h2, 4'h0}; // R10
      M_PCDISP: c = lng ? '{8'h0c, 4'h3, 4'h0} : '{8'h08, 4'h2, 4'h0}; // R10
      M_PCINDEX: c = lng ? '{8'h0e, 4'h3, 4'h0} : '{8'h0a, 4'h2, 4'h0}; // R11 R12
      M_IMM: c = lng ? '{8'h08, 4'h2, 4'h0} : '{8'h04, 4'h1, 4'h0}; // R11
      default: c = '0;
    endcase
    return c;
  endfunction

  function automatic logic is_reg(ict_mode_e m);
    return (m == M_DREG) || (m == M_AREG);
  endfunction

  // Only a single-word byte/word move between these modes can loop.
  function automatic logic loopable(ict_req_s q);
    logic src_ok;
    logic dst_ok;
    src_ok = is_reg(q.src) || q.src == M_IND || q.src == M_POST || q.src == M_PRE;
    dst_ok = q.dst == M_IND || q.dst == M_POST || (q.dst == M_PRE && !is_reg(q.src));
    return (q.op == OP_MOVE) && !q.size_long && src_ok && dst_ok;
  endfunction

  function automatic ict_cost_s cost_of(ict_req_s q, logic in_loop);
    ict_cost_s src;
    ict_cost_s dst;
    ict_cost_s c;
    src = ea_cost(q.src, q.size_long, 1'b1);
    dst = ea_cost(q.dst, 1'b0, 1'b1);
    c = '0;
    if (q.op == OP_EA) begin
      c = ea_cost(q.src, q.size_long, q.fetch); // R5
    end else if (in_loop && loopable(q)) begin
      if (q.loop_condition) begin
        c = is_reg(q.src) ? LOOP_TRUE_REG : LOOP_TRUE_MEM; // R16
      end else if (q.count_expired) begin
        c = is_reg(q.src) ? LOOP_EXP_REG : LOOP_EXP_MEM; // R17
      end else begin
        c = is_reg(q.src) ? LOOP_CONT_REG : LOOP_CONT_MEM; // R15
      end
      if (q.src == M_PRE) begin
        c.periods = c.periods + PREDEC_EXTRA; // R15 R16 R17
      end
      if (q.dst == M_PRE) begin
        c.periods = c.periods + PREDEC_EXTRA; // R15 R16 R17
      end
    end else begin
      if (is_reg(q.dst)) begin
        dst = '0;
      end else begin
        if (q.dst == M_PRE) begin
          dst.periods = PREDEC_DEST_PERIODS;
        end
        // The destination's last operand read becomes the store.
        dst.reads = dst.reads - 4'h1; // R13 R14
        dst.writes = q.size_long ? LONG_DEST_WRITES : BW_DEST_WRITES; // R19
        if (q.size_long) begin
          dst.periods = dst.periods + LONG_DEST_EXTRA; // R19
        end
        if (q.size_long && q.dst == M_PRE && is_reg(q.src)) begin
          dst.periods = dst.periods + PREDEC_EXTRA; // R19
        end
      end
      c.periods = OPCODE_COST.periods + src.periods + dst.periods; // R3 R13 R14
      c.reads = OPCODE_COST.reads + src.reads + dst.reads; // R3
      c.writes = dst.writes; // R3
    end
    return c;
  endfunction

  // Reads first, then internal periods, then writes.
  function automatic ict_state_e pick(logic [3:0] rd, logic [7:0] idle, logic [3:0] wr);
    ict_state_e st;
    if (rd != 4'h0) begin
      st = ST_READ;
    end else if (idle != 8'h00) begin
      st = ST_INTERN;
    end else if (wr != 4'h0) begin
      st = ST_WRITE;
    end else begin
      st = ST_IDLE;
    end
    return st;
  endfunction

  // =====================================================================
  // State.
  ict_st_s s_r;
  ict_st_s s_nxt;
  ict_cost_s plan_c;
  logic finish_c;
  logic in_bus;

  assign in_bus = (s_r.state == ST_READ) || (s_r.state == ST_WRITE);
  assign req_ready_out = (s_r.state == ST_IDLE);
  assign bus_start_out = in_bus && (s_r.phase == 2'h0);
  assign bus_read_out = (s_r.state == ST_READ);
  assign bus_write_out = (s_r.state == ST_WRITE);
  assign done_out = s_r.done;
  assign result_out = s_r.result;
  assign loop_active_out = s_r.loop_active;
  assign opcode_fetch_skip_out = s_r.loop_active; // R18

  always_comb begin
    s_nxt = s_r;
    plan_c = '0;
    finish_c = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.wait_sync = {s_r.wait_sync[1:0], mem_wait_in};
    if (s_r.wait_sync[1] == s_r.wait_sync[2]) begin
      s_nxt.wait_q = s_r.wait_sync[2];
    end
    case (s_r.state)
      ST_IDLE: begin
        if (req_valid_in) begin
          plan_c = cost_of(req_in, s_r.loop_active);
          s_nxt.plan = plan_c;
          s_nxt.is_ea = (req_in.op == OP_EA);
          s_nxt.rd_left = plan_c.reads;
          s_nxt.wr_left = plan_c.writes;
          s_nxt.idle_left = plan_c.periods - 8'({plan_c.reads + plan_c.writes, 2'b00}); // R4
          s_nxt.periods = '0;
          s_nxt.waits = '0;
          s_nxt.rd_done = '0;
          s_nxt.wr_done = '0;
          s_nxt.phase = 2'h0;
          if (s_r.loop_active && loopable(req_in)) begin
            s_nxt.loop_active = !(req_in.loop_condition || req_in.count_expired); // R16 R17
          end else begin
            s_nxt.loop_active = req_in.loop_candidate && req_in.branch_to_self && loopable(req_in); // R18
          end
          s_nxt.state = pick(s_nxt.rd_left, s_nxt.idle_left, s_nxt.wr_left);
          finish_c = (s_nxt.state == ST_IDLE);
        end
      end
      ST_READ, ST_WRITE: begin
        s_nxt.periods = s_r.periods + 16'h0001;
        if (s_r.phase != BUS_LAST_PHASE) begin
          s_nxt.phase = s_r.phase + 2'h1; // R1
        end else if (s_r.wait_q) begin
          s_nxt.waits = s_r.waits + 16'h0001; // R2
        end else begin
          s_nxt.phase = 2'h0;
          if (s_r.state == ST_READ) begin
            s_nxt.rd_left = s_r.rd_left - 4'h1;
            s_nxt.rd_done = s_r.rd_done + 4'h1;
          end else begin
            s_nxt.wr_left = s_r.wr_left - 4'h1;
            s_nxt.wr_done = s_r.wr_done + 4'h1;
          end
          s_nxt.state = pick(s_nxt.rd_left, s_nxt.idle_left, s_nxt.wr_left);
          finish_c = (s_nxt.state == ST_IDLE);
        end
      end
      ST_INTERN: begin
        s_nxt.periods = s_r.periods + 16'h0001;
        s_nxt.idle_left = s_r.idle_left - 8'h01; // R4
        s_nxt.state = pick(s_nxt.rd_left, s_nxt.idle_left, s_nxt.wr_left);
        finish_c = (s_nxt.state == ST_IDLE);
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase
    if (finish_c) begin
      s_nxt.done = 1'b1;
      s_nxt.result = '{s_nxt.periods, s_nxt.rd_done, s_nxt.wr_done, s_nxt.waits}; // R2 R3
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '{state: ST_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // =====================================================================
  // Checks.
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  logic accept;
  assign accept = req_valid_in && req_ready_out;

  sequence s_move_accept;
    accept && req_in.op == OP_MOVE;
  endsequence

  sequence s_loop_accept;
    accept && s_r.loop_active && loopable(req_in);
  endsequence

  AST_BUS_FOUR: assert property (bus_start_out |-> (bus_read_out || bus_write_out) [*4]) // R1
    else $error("bus cycle shorter than four periods");

  AST_BUS_END: assert property (in_bus && s_r.phase == BUS_LAST_PHASE && !s_r.wait_q |=> !in_bus || bus_start_out) // R1
    else $error("unstretched bus cycle did not end at its fourth period");

  AST_WAIT_STRETCH: assert property (in_bus && s_r.phase == BUS_LAST_PHASE && s_r.wait_q |=> // R2
      in_bus && s_r.phase == BUS_LAST_PHASE && s_r.waits == $past(s_r.waits) + 16'h0001)
    else $error("wait period not added to bus cycle");

  AST_TOTAL: assert property (done_out |-> result_out.periods == 16'(s_r.plan.periods) + result_out.waits) // R2 R4
    else $error("total periods differ from plan plus waits");

  AST_RW_COUNT: assert property (done_out |-> result_out.reads == s_r.plan.reads && // R3
      result_out.writes == s_r.plan.writes)
    else $error("read or write count differs from plan");

  AST_EA_NO_WRITE: assert property (s_r.is_ea |-> !bus_write_out) // R5
    else $error("address computation performed a write");

  AST_REG_DIRECT: assert property (accept && req_in.op == OP_EA && is_reg(req_in.src) |=> // R6
      done_out && result_out.periods == 16'h0000 && req_ready_out)
    else $error("register direct operand cost time");

  // The memory may stretch this read, so only its unstretched fourth period is checked.
  AST_EA_IND: assert property (accept && req_in.op == OP_EA && req_in.src == M_IND && req_in.fetch && // R7
      !req_in.size_long |=> s_r.plan == OPCODE_COST ##3 bus_read_out && s_r.phase == BUS_LAST_PHASE)
    else $error("indirect fetch cost wrong");

  AST_INTERNAL_IDLE: assert property (s_r.state == ST_INTERN |-> !bus_read_out && !bus_write_out) // R4
    else $error("bus active during internal period");

  AST_WRITE_LAST: assert property (bus_write_out |-> s_r.rd_left == 4'h0 && s_r.idle_left == 8'h00) // R3
    else $error("write issued before reads and internal periods finished");

  AST_MOVE_REG: assert property (s_move_accept and (!s_r.loop_active && !req_in.size_long && // R13
      req_in.src == M_DREG && req_in.dst == M_ABSL) |=> s_r.plan == '{8'h10, 4'h3, 4'h1})
    else $error("register to absolute long move cost wrong");

  AST_MOVE_MEM: assert property (s_move_accept and (!s_r.loop_active && !req_in.size_long && // R14
      req_in.src == M_ABSL && req_in.dst == M_ABSL) |=> s_r.plan == '{8'h1c, 4'h6, 4'h1})
    else $error("absolute long to absolute long move cost wrong");

  AST_LOOP_CONT: assert property (s_loop_accept and (is_reg(req_in.src) && !req_in.loop_condition && // R15
      !req_in.count_expired) |=> s_r.plan == LOOP_CONT_REG && s_r.loop_active && opcode_fetch_skip_out)
    else $error("continuing loop cost wrong");

  AST_LOOP_TRUE: assert property (s_loop_accept and req_in.loop_condition |=> // R16
      !s_r.loop_active && s_r.plan.periods >= 8'h12 && s_r.plan.periods <= 8'h18)
    else $error("loop end on condition wrong");

  AST_LOOP_EXP: assert property (s_loop_accept and (!req_in.loop_condition && req_in.count_expired) |=> // R17
      !s_r.loop_active && s_r.plan.periods >= 8'h10 && s_r.plan.periods <= 8'h16)
    else $error("loop end on expired count wrong");

  AST_LOOP_ENTRY: assert property (accept && !s_r.loop_active && !(req_in.loop_candidate && // R18
      req_in.branch_to_self) |=> !s_r.loop_active)
    else $error("loop mode entered without a looping pair");

  AST_LONG_WRITES: assert property (s_move_accept and (!s_r.loop_active && req_in.size_long && // R19
      req_in.src == M_DREG && req_in.dst == M_IND) |=> s_r.plan == '{8'h0c, 4'h1, 4'h2})
    else $error("long move cost wrong");

  // =====================================================================
  // Checks on the internal counters, the wait synchroniser, address results, memory loop plans and the write after the last read.
  // Every internal period must use up exactly one planned idle period.
  AST_INTERN_COUNT: assert property (s_r.state == ST_INTERN |=> // R4
      s_r.idle_left == $past(s_r.idle_left) - 8'h01)
    else $error("internal period not counted");

  // The filtered wait level may only follow two agreeing late stages.
  AST_WAIT_SYNC: assert property ($changed(s_r.wait_q) |-> // R2
      $past(s_r.wait_sync[2]) == $past(s_r.wait_sync[1]) && s_r.wait_q == $past(s_r.wait_sync[2]))
    else $error("wait level changed without agreeing stages");

  AST_EA_RESULT: assert property (done_out && s_r.is_ea |-> result_out.writes == 4'h0) // R5
    else $error("address computation reported a write");

  // A continuing loop from memory reads its operand but never the opcode.
  AST_LOOP_MEM: assert property (s_loop_accept and (req_in.src == M_IND && !req_in.loop_condition && // R15
      !req_in.count_expired) |=> s_r.plan.reads == 4'h1 && s_r.plan.writes == 4'h1 && opcode_fetch_skip_out)
    else $error("continuing memory loop fetched an opcode");

  // Nothing but a write cycle may follow the last read when no idle period is planned.
  AST_READ_TO_WRITE: assert property (bus_read_out && s_r.phase == BUS_LAST_PHASE && !s_r.wait_q && // R3
      s_r.rd_left == 4'h1 && s_r.idle_left == 8'h00 && s_r.wr_left != 4'h0 |=> bus_write_out && bus_start_out)
    else $error("write did not follow the last read");

endmodule // ict_core

// ---- ict_mem_model.sv ----
`timescale 1ns/1ps

// =====================================================================
// Memory side: stretches bus cycles by holding the wait line high.
module ict_mem_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic bus_start_in,
  input wire logic [3:0] hold_in,
  output logic mem_wait_out
);
  logic [3:0] left_r;

  // A stretch starts with each bus cycle; a hold of zero answers promptly.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      left_r <= 4'h0;
    end else if (bus_start_in) begin
      left_r <= hold_in;
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
    end
  end

  assign mem_wait_out = (left_r != 4'h0);
endmodule // ict_mem_model

// ---- tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

module tb;
  import ict_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid_in = 1'b0;
  ict_req_s req_in = '0;
  logic req_ready_out, mem_wait_in, bus_start_out, bus_read_out, bus_write_out, done_out;
  logic loop_active_out, skip_out;
  ict_result_s result_out;
  logic [3:0] hold = 4'h0;
  int miscompares = 0;
  int samples_checked = 0;
  int loop_on = 0;
  int bwf_p[12] = '{0, 0, 4, 4, 6, 8, 10, 8, 12, 8, 10, 4};
  int bwf_r[12] = '{0, 0, 1, 1, 1, 2, 2, 2, 3, 2, 2, 1};
  int lf_p[12] = '{0, 0, 8, 8, 10, 12, 14, 12, 16, 12, 14, 8};
  int lf_r[12] = '{0, 0, 2, 2, 2, 3, 3, 3, 4, 3, 3, 2};
  int nf_p[9] = '{0, 0, 2, 4, 4, 4, 8, 4, 8};
  int nf_r[9] = '{0, 0, 0, 0, 0, 0, 1, 1, 2};
  int dp[9] = '{0, 0, 4, 4, 4, 8, 10, 8, 12};
  int dr[9] = '{0, 0, 0, 0, 0, 1, 1, 1, 2};
  int codes[7] = '{0, 0, 2, 0, 1, 0, 3};

  ict_core dut (.clock_in(clock_in), .rst_in(rst_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .mem_wait_in(mem_wait_in), .bus_start_out(bus_start_out),
    .bus_read_out(bus_read_out), .bus_write_out(bus_write_out), .done_out(done_out),
    .result_out(result_out), .loop_active_out(loop_active_out), .opcode_fetch_skip_out(skip_out));

  ict_mem_model mem (.clock_in(clock_in), .rst_in(rst_in), .bus_start_in(bus_start_out), .hold_in(hold),
    .mem_wait_out(mem_wait_in));

  always #25 clock_in = ~clock_in;

  // =====================================================================
  // Closing report.
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // =====================================================================
  // Reference model of the cycle costs.
  function automatic int loopable(ict_req_s q);
    return q.op == OP_MOVE && !q.size_long && q.src <= M_PRE && q.dst >= M_IND && q.dst <= M_PRE &&
      !(q.src <= M_AREG && q.dst == M_PRE);
  endfunction

  task automatic ea(input int m, input logic lng, input logic f, output int p, output int r);
    if (f || m >= 9 || m <= 1) begin
      p = lng ? lf_p[m] : bwf_p[m];
      r = lng ? lf_r[m] : bwf_r[m];
    end else begin
      p = nf_p[m];
      r = (lng && m == 5) ? 1 : nf_r[m];
    end
  endtask

  task automatic model(input ict_req_s q, output int p, output int r, output int w);
    int pre;
    int mm;
    pre = (q.src == M_PRE) + (q.dst == M_PRE);
    mm = (q.src >= M_IND) ? 1 : 0;
    if (q.op == OP_EA) begin
      ea(int'(q.src), q.size_long, q.fetch, p, r);
      w = 0;
      loop_on = 0;
    end else if (loop_on != 0 && loopable(q) != 0 && q.loop_candidate && q.branch_to_self) begin
      w = 1;
      if (q.loop_condition) begin
        p = 18 + 2 * mm + 2 * pre;
        r = 2 + mm;
        loop_on = 0;
      end else if (q.count_expired) begin
        p = 16 + 2 * mm + 2 * pre;
        r = 2 + mm;
        loop_on = 0;
      end else begin
        p = 10 + 4 * mm + 2 * pre;
        r = mm;
      end
    end else begin
      ea(int'(q.src), q.size_long, 1'b1, p, r);
      p = p + 4 + dp[q.dst] + ((q.size_long && q.dst >= M_IND) ? 4 : 0);
      r = r + 1 + dr[q.dst];
      w = (q.dst >= M_IND) ? (q.size_long ? 2 : 1) : 0;
      loop_on = (loopable(q) != 0 && q.loop_candidate && q.branch_to_self) ? 1 : 0;
    end
  endtask

  // =====================================================================
  // One request, measured at the bus and compared with the model.
  task automatic run(input ict_req_s q, input logic [3:0] h);
    int p, r, w, n, act, rs, ws;
    model(q, p, r, w);
    n = 0;
    act = 0;
    rs = 0;
    ws = 0;
    @(posedge clock_in);
    req_in <= q;
    req_valid_in <= 1'b1;
    hold <= h;
    @(negedge clock_in);
    while (req_ready_out !== 1'b1) begin
      n++;
      if (n > 1000) begin
        miscompares++;
        finish_test();
      end
      @(negedge clock_in);
    end
    @(posedge clock_in);
    req_valid_in <= 1'b0;
    n = 0;
    @(negedge clock_in);
    while (done_out !== 1'b1) begin
      n++;
      act += (bus_read_out === 1'b1 || bus_write_out === 1'b1) ? 1 : 0;
      rs += (bus_start_out === 1'b1 && bus_read_out === 1'b1) ? 1 : 0;
      ws += (bus_start_out === 1'b1 && bus_write_out === 1'b1) ? 1 : 0;
      if (n > 1000) begin
        miscompares++;
        finish_test();
      end
      @(negedge clock_in);
    end
    `CHK(result_out.reads, 4'(r))
    `CHK(result_out.writes, 4'(w))
    `CHK(result_out.periods, 16'(p + act - 4 * (r + w)))
    `CHK(result_out.periods, 16'(n))
    `CHK(result_out.waits, 16'(act - 4 * (r + w)))
    `CHK(16'(n - act), 16'(p - 4 * (r + w)))
    `CHK(4'(rs), 4'(r))
    `CHK(4'(ws), 4'(w))
    `CHK(loop_active_out, 1'(loop_on != 0))
    `CHK(skip_out, 1'(loop_on != 0))
  endtask

  // =====================================================================
  // Main sequence.
  initial begin
    ict_req_s q;
    int s, d, k;
    void'($urandom(32'h6eb459b0));
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    for (s = 0; s < 48; s++) begin
      q = '0;
      q.op = OP_EA;
      q.src = ict_mode_e'(s % 12);
      q.dst = q.src;
      q.size_long = s[4];
      q.fetch = s[5] | ~s[4];
      run(q, 4'h0);
    end
    for (s = 0; s < 12; s++) begin
      for (d = 0; d < 9; d++) begin
        q = '0;
        q.op = OP_MOVE;
        q.src = ict_mode_e'(s);
        q.dst = ict_mode_e'(d);
        run(q, (s == d) ? 4'h6 : 4'h0);
      end
    end
    q = '0;
    q.op = OP_MOVE;
    q.size_long = 1'b1;
    q.dst = M_IND;
    run(q, 4'h0);
    q.src = M_ABSL;
    q.dst = M_DREG;
    run(q, 4'hc);
    for (s = 0; s < 5; s++) begin
      for (d = 2; d < 5; d++) begin
        for (k = 0; k < 7; k++) begin
          q = '0;
          q.op = OP_MOVE;
          q.src = ict_mode_e'(s);
          q.dst = ict_mode_e'(d);
          q.loop_candidate = 1'b1;
          q.branch_to_self = 1'b1;
          q.loop_condition = codes[k][1];
          q.count_expired = codes[k][0];
          run(q, 4'(k % 2 * 5));
        end
        q.op = OP_EA;
        run(q, 4'h0);
      end
    end
    repeat (60) begin
      q = ict_req_s'(15'($urandom));
      q.src = ict_mode_e'($urandom % 12);
      q.dst = ict_mode_e'($urandom % 9);
      q.loop_candidate = 1'b0;
      q.size_long = (q.op == OP_MOVE) ? 1'b0 : q.size_long;
      run(q, 4'($urandom % 3 * 5));
    end
    finish_test();
  end
endmodule // tb
